//--- include/sysconfig_pkg.sv
// Operation
// RL1 - First register bits 31:11 read zero
// RL2 - Boot flags report the boot mode taken
// RL3 - Loader flag only for debug-loaded system boot
// RL4 - Bit 5 routes DMA: timers or serial one
// RL5 - Bit 4 routes DMA to serial zero
// RL6 - Software keeps bits 3:1 at zero
// RL7 - Ram_at_zero_select bit adds RAM at address zero
// RL8 - Second register bits 31:8 read zero
// RL9 - Flash power-on delayed after low-power wait exit
// RL10 - Delay may overrun by one RC period
// RL11 - Software sizes delay for regulator settling
// RL12 - Bit 3 picks wake line zero source
// RL13 - Filter drops one-cycle external interrupt pulses
// RL14 - Two-bit field selects regulator current
// RL15 - Identification register fixed and read-only
// RL16 - Three trigger bits choose each line's event
// RL17 - Trigger registers bits 31:16 read zero
// RL18 - Trigger code table is a parameter
// RL19 - Boot flags captured once after reset
package sysconfig_pkg;
  localparam logic [7:0]  OFS_BOOT_RAM_AT_ZERO_SELECT    = 8'h00;
  localparam logic [7:0]  OFS_TRIG_A        = 8'h04;
  localparam logic [7:0]  OFS_TRIG_B        = 8'h24;
  localparam logic [7:0]  OFS_TRIG_C        = 8'h28;
  localparam logic [7:0]  OFS_POWER_WAKE    = 8'h30;
  localparam logic [7:0]  OFS_DEVICE_ID     = 8'h34;
  localparam logic [7:0]  OFS_EVENT_STATUS  = 8'h38;
  localparam logic [7:0]  OFS_EVENT_MASK    = 8'h3c;

  localparam logic [15:0] RST_TRIG_A        = 16'hffff;
  localparam logic [15:0] RST_TRIG_B        = 16'h0000;
  localparam logic [15:0] RST_TRIG_C        = 16'h0000;
  localparam logic [7:0]  RST_POWER_WAKE    = 8'h40;

  // Boot and ram_at_zero_select register fields
  localparam int BIT_SYSMEM    = 10;
  localparam int BIT_USER_ONE  = 9;
  localparam int BIT_USER_TWO  = 8;
  localparam int BIT_LOADER    = 7;
  localparam int BIT_DMA_SER1  = 5;
  localparam int BIT_DMA_SER0  = 4;
  localparam int BIT_RAM_AT_ZERO_SELECT     = 0;
  // Power and wake register fields
  localparam int POS_FLASH_DELAY = 4;
  localparam int BIT_WAKE_SRC  = 3;
  localparam int BIT_FILTER    = 2;
  localparam int POS_LPCUR     = 0;

  // Event status bits
  localparam int EV_FLASH_ON   = 0;
  localparam int EV_WAIT_EXIT  = 1;
  localparam int EV_EXT_IRQ    = 2;
  localparam int NUM_EVENTS    = 3;

  localparam logic [3:0] RAM_REGION   = 4'ha;
  localparam logic [3:0] FLASH_REGION = 4'h0;
  localparam int         FAST_RC_MULT = 64;
  localparam logic [1:0] BOOT_SETTLE  = 2'h3;

  // Trigger kinds addressed by the per-line code {c,b,a}
  localparam logic [2:0] KIND_NONE = 3'h0;
  localparam logic [2:0] KIND_LOW  = 3'h1;
  localparam logic [2:0] KIND_HIGH = 3'h2;
  localparam logic [2:0] KIND_FALL = 3'h3;
  localparam logic [2:0] KIND_RISE = 3'h4;
  localparam logic [2:0] KIND_BOTH = 3'h5;

  typedef struct packed {
    logic sysmem;
    logic user_one;
    logic user_two;
    logic loader_in_ram;
  } boot_strap_t;

  typedef enum logic [1:0] {FLASH_ON, FLASH_WAIT, FLASH_COUNT} flash_state_t;
endpackage

//--- verilog/system_config_registers.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module system_config_registers
  import sysconfig_pkg::*;
#(
  parameter int          LINES      = 16,
  parameter logic [31:0] DEVICE_ID  = 32'h0000_5a5a, // Arbitrary value
  parameter logic [23:0] TRIG_TABLE = {KIND_NONE, KIND_NONE, KIND_BOTH, KIND_RISE,
                                       KIND_FALL, KIND_HIGH, KIND_LOW, KIND_NONE}
) (
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Boot straps, asynchronous pins
  input  wire boot_strap_t       boot_strap,
  // Memory decode
  input  wire logic [31:0]       mem_addr,
  output logic                   ram_select,
  output logic                   flash_select,
  output logic                   ram_at_zero_select,
  // DMA routing
  output logic                   dma_serial1_route,
  output logic                   dma_serial0_route,
  // Low-power wait and flash power
  input  wire logic              low_power_wait_mode,
  input  wire logic              rc_clk,
  input  wire logic              rc_slow_sel,
  output logic                   flash_power_on,
  // Wake-up line zero
  input  wire logic              wake_pin_zero,
  input  wire logic              wut_end_of_count,
  output logic                   wake_line0,
  // External interrupts towards the interrupt controller
  input  wire logic [LINES-1:0]  ext_irq,
  output logic      [LINES-1:0]  irq_request,
  // Regulator
  output logic      [1:0]        lp_regulator_current_sel,
  output logic      [2:0]        lp_reg_current_ma,
  // Event interrupt
  output logic                   irq
);

  function automatic logic [2:0] current_ma(input logic [1:0] code);
    case (code)
      2'h0:    current_ma = 3'h6;
      2'h3:    current_ma = 3'h2;
      default: current_ma = 3'h4;
    endcase
  endfunction
  function automatic logic [2:0] kind_of(input logic [2:0] code);
    kind_of = TRIG_TABLE[code*3 +: 3];
  endfunction
  logic              sysmem_boot_flag, user_one_boot_flag, user_two_boot_flag;
  logic              debug_loader_boot_flag;
  logic [15:0]       trig_a_reg, trig_b_reg, trig_c_reg;
  logic [7:0]        pw_reg;
  logic [NUM_EVENTS-1:0] status_reg, mask_reg, event_set;
  logic [31:0]       rdata_next;
  logic              map_hit;
  logic              wr_acc;

  assign wr_acc = psel && penable && pready && pwrite;
  // APB: data prepared in setup, answered with no wait state
  always_comb begin
    rdata_next = 32'h0000_0000;
    map_hit    = 1'b1;
    case (paddr)
      OFS_BOOT_RAM_AT_ZERO_SELECT:   rdata_next = {21'h000000, sysmem_boot_flag, user_one_boot_flag,
                                      user_two_boot_flag, debug_loader_boot_flag, 1'b0,
                                      dma_serial1_route, dma_serial0_route,
                                      3'h0, ram_at_zero_select}; // RL1
      OFS_TRIG_A:       rdata_next = {16'h0000, trig_a_reg}; // RL17
      OFS_TRIG_B:       rdata_next = {16'h0000, trig_b_reg}; // RL17
      OFS_TRIG_C:       rdata_next = {16'h0000, trig_c_reg}; // RL17
      OFS_POWER_WAKE:   rdata_next = {24'h000000, pw_reg}; // RL8
      OFS_DEVICE_ID:    rdata_next = DEVICE_ID; // RL15
      OFS_EVENT_STATUS: rdata_next = {29'h0000000, status_reg};
      OFS_EVENT_MASK:   rdata_next = {29'h0000000, mask_reg};
      default:          map_hit    = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !map_hit;
      if (psel && !penable && !pwrite) begin
        prdata <= rdata_next;
      end
    end
  end

  // Boot straps: synchronise, wait to settle, capture once
  boot_strap_t boot_s1, boot_s2;
  logic [1:0]  boot_cnt;
  logic        boot_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_s1 <= '0;
      boot_s2 <= '0;
    end else begin
      boot_s1 <= boot_strap;
      boot_s2 <= boot_s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_cnt               <= 2'h0;
      boot_done              <= 1'b0;
      sysmem_boot_flag       <= 1'b0;
      user_one_boot_flag     <= 1'b0;
      user_two_boot_flag     <= 1'b0;
      debug_loader_boot_flag <= 1'b0;
    end else if (!boot_done) begin
      boot_cnt <= boot_cnt + 2'h1;
      if (boot_cnt == BOOT_SETTLE) begin // RL19
        boot_done <= 1'b1;
        // Priority keeps at most one mode flagged
        sysmem_boot_flag       <= boot_s2.sysmem; // RL2
        user_one_boot_flag     <= !boot_s2.sysmem && boot_s2.user_one; // RL2
        user_two_boot_flag     <= !boot_s2.sysmem && !boot_s2.user_one && boot_s2.user_two; // RL2
        debug_loader_boot_flag <= boot_s2.sysmem && boot_s2.loader_in_ram; // RL3
      end
    end
  end

  // Writable configuration; bits 3:1 of the first register are not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_serial1_route  <= 1'b0;
      dma_serial0_route  <= 1'b0;
      ram_at_zero_select <= 1'b0;
    end else if (wr_acc && paddr == OFS_BOOT_RAM_AT_ZERO_SELECT) begin
      dma_serial1_route  <= pwdata[BIT_DMA_SER1]; // RL4
      dma_serial0_route  <= pwdata[BIT_DMA_SER0]; // RL5
      ram_at_zero_select <= pwdata[BIT_RAM_AT_ZERO_SELECT]; // RL7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_a_reg <= RST_TRIG_A;
      trig_b_reg <= RST_TRIG_B;
      trig_c_reg <= RST_TRIG_C;
    end else if (wr_acc) begin
      if (paddr == OFS_TRIG_A) trig_a_reg <= pwdata[15:0];
      if (paddr == OFS_TRIG_B) trig_b_reg <= pwdata[15:0];
      if (paddr == OFS_TRIG_C) trig_c_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pw_reg <= RST_POWER_WAKE;
    end else if (wr_acc && paddr == OFS_POWER_WAKE) begin
      pw_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= '0;
    end else if (wr_acc && paddr == OFS_EVENT_MASK) begin
      mask_reg <= pwdata[NUM_EVENTS-1:0];
    end
  end

  // Sticky events; a new event beats a simultaneous clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
      irq        <= 1'b0;
    end else begin
      if (wr_acc && paddr == OFS_EVENT_STATUS) begin
        status_reg <= (status_reg & ~pwdata[NUM_EVENTS-1:0]) | event_set;
      end else begin
        status_reg <= status_reg | event_set;
      end
      irq <= |(status_reg & mask_reg);
    end
  end

  // Memory decode with ram_at_zero_select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_select   <= 1'b0;
      flash_select <= 1'b0;
    end else begin
      ram_select   <= (mem_addr[31:28] == RAM_REGION) ||
                      (ram_at_zero_select && mem_addr[31:28] == FLASH_REGION); // RL7
      flash_select <= !ram_at_zero_select && mem_addr[31:28] == FLASH_REGION; // RL7
    end
  end

  // Regulator current and wake line
  logic wake_s1, wake_s2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_s1                  <= 1'b0;
      wake_s2                  <= 1'b0;
      wake_line0               <= 1'b0;
      lp_regulator_current_sel <= 2'h0;
      lp_reg_current_ma        <= 3'h6;
    end else begin
      wake_s1                  <= wake_pin_zero;
      wake_s2                  <= wake_s1;
      wake_line0               <= pw_reg[BIT_WAKE_SRC] ? wut_end_of_count : wake_s2; // RL12
      lp_regulator_current_sel <= pw_reg[POS_LPCUR +: 2];
      lp_reg_current_ma        <= current_ma(pw_reg[POS_LPCUR +: 2]); // RL14
    end
  end

  // Flash power-on delay, counted in RC clock periods
  logic [2:0]   rc_sync;
  logic [1:0]   lpw_sync;
  logic [1:0]   slow_sync;
  logic         lpw_prev;
  logic [9:0]   rc_cnt;
  logic [9:0]   delay_target;
  flash_state_t flash_state;
  logic         rc_tick;

  assign rc_tick = rc_sync[1] && !rc_sync[2];
  assign delay_target = slow_sync[1] ? {6'h00, pw_reg[POS_FLASH_DELAY +: 4]}
                                     : 10'(pw_reg[POS_FLASH_DELAY +: 4] * FAST_RC_MULT); // RL9

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_sync   <= 3'h0;
      lpw_sync  <= 2'h0;
      slow_sync <= 2'h0;
      lpw_prev  <= 1'b0;
    end else begin
      rc_sync   <= {rc_sync[1:0], rc_clk};
      lpw_sync  <= {lpw_sync[0], low_power_wait_mode};
      slow_sync <= {slow_sync[0], rc_slow_sel};
      lpw_prev  <= lpw_sync[1];
    end
  end

  // One tick beyond delay_target: the first period is partial, so never short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_state    <= FLASH_ON;
      rc_cnt         <= 10'h000;
      flash_power_on <= 1'b1;
    end else begin
      case (flash_state)
        FLASH_ON: begin
          if (lpw_sync[1]) begin
            flash_state    <= FLASH_WAIT;
            flash_power_on <= 1'b0;
          end
        end
        FLASH_WAIT: begin
          if (!lpw_sync[1]) begin
            flash_state <= FLASH_COUNT;
            rc_cnt      <= 10'h000;
          end
        end
        FLASH_COUNT: begin
          if (rc_cnt > delay_target) begin // RL10
            flash_state    <= FLASH_ON;
            flash_power_on <= 1'b1; // RL9
          end else if (rc_tick) begin
            rc_cnt <= rc_cnt + 10'h001;
          end
        end
        default: begin
          flash_state    <= FLASH_ON;
          flash_power_on <= 1'b1;
        end
      endcase
    end
  end

  // External interrupt lines: sync, glitch filter, event detect
  logic [LINES-1:0] ei_s1, ei_s2, ei_s3, ei_filt, ei_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ei_s1   <= '0;
      ei_s2   <= '0;
      ei_s3   <= '0;
      ei_filt <= '0;
      ei_prev <= '0;
    end else begin
      ei_s1   <= ext_irq;
      ei_s2   <= ei_s1;
      ei_s3   <= ei_s2;
      ei_prev <= ei_filt;
      for (int n = 0; n < LINES; n++) begin
        // With the filter bit set, two equal samples are needed, so a one-cycle pulse never passes
        if (!pw_reg[BIT_FILTER] || ei_s2[n] == ei_s3[n]) begin
          ei_filt[n] <= ei_s2[n]; // RL13
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request <= '0;
    end else begin
      for (int n = 0; n < LINES; n++) begin
        case (kind_of({trig_c_reg[n], trig_b_reg[n], trig_a_reg[n]})) // RL16 RL18
          KIND_LOW:  irq_request[n] <= !ei_filt[n];
          KIND_HIGH: irq_request[n] <= ei_filt[n];
          KIND_FALL: irq_request[n] <= ei_prev[n] && !ei_filt[n];
          KIND_RISE: irq_request[n] <= !ei_prev[n] && ei_filt[n];
          KIND_BOTH: irq_request[n] <= ei_prev[n] != ei_filt[n];
          default:   irq_request[n] <= 1'b0;
        endcase
      end
    end
  end

  logic [LINES-1:0] irq_req_prev;
  logic             flash_prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_prev <= '0;
      flash_prev   <= 1'b1;
    end else begin
      irq_req_prev <= irq_request;
      flash_prev   <= flash_power_on;
    end
  end

  always_comb begin
    event_set               = '0;
    event_set[EV_FLASH_ON]  = flash_power_on && !flash_prev;
    event_set[EV_WAIT_EXIT] = lpw_prev && !lpw_sync[1];
    event_set[EV_EXT_IRQ]   = |(irq_request & ~irq_req_prev);
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_r0_reserved_zero: assert property ( // RL1
    psel && penable && !pwrite && paddr == OFS_BOOT_RAM_AT_ZERO_SELECT |-> prdata[31:11] == 21'h000000)
    else $error("boot/ram_at_zero_select reserved bits not zero");
  chk_boot_onehot: assert property ( // RL2
    $onehot0({sysmem_boot_flag, user_one_boot_flag, user_two_boot_flag}))
    else $error("more than one boot flag set");
  chk_loader_needs_sysmem: assert property ( // RL3
    debug_loader_boot_flag |-> sysmem_boot_flag)
    else $error("loader flag without system boot");
  chk_dma_route_write: assert property ( // RL4
    wr_acc && paddr == OFS_BOOT_RAM_AT_ZERO_SELECT |=>
      dma_serial1_route == $past(pwdata[5]) && dma_serial0_route == $past(pwdata[4]))
    else $error("dma route not written");
  chk_ram_at_zero_select_decode: assert property ( // RL7
    ram_at_zero_select && mem_addr[31:28] == 4'h0 |=> ram_select && !flash_select)
    else $error("ram_at_zero_select decode wrong");
  chk_r1_reserved_zero: assert property ( // RL8
    psel && penable && !pwrite && paddr == OFS_POWER_WAKE |-> prdata[31:8] == 24'h000000)
    else $error("power register reserved bits not zero");
  chk_flash_held_off: assert property ( // RL9
    flash_state == FLASH_COUNT && rc_cnt <= delay_target |=> !flash_power_on)
    else $error("flash powered before delay elapsed");
  chk_wake_source: assert property ( // RL12
    pw_reg[3] && $stable(pw_reg) |=> wake_line0 == $past(wut_end_of_count))
    else $error("wake line zero source wrong");
  chk_filter_glitch: assert property ( // RL13
    pw_reg[2] && ei_s2[0] != ei_s3[0] |=> ei_filt[0] == $past(ei_filt[0]))
    else $error("glitch passed the filter");
  chk_current_code: assert property ( // RL14
    pw_reg[1:0] == 2'h3 |=> lp_reg_current_ma == 3'h2)
    else $error("regulator current code wrong");
  chk_id_fixed: assert property ( // RL15
    psel && penable && !pwrite && paddr == OFS_DEVICE_ID |-> prdata == DEVICE_ID)
    else $error("identification value changed");
  chk_trig_reserved_zero: assert property ( // RL17
    psel && penable && !pwrite && paddr == OFS_TRIG_B |-> prdata[31:16] == 16'h0000)
    else $error("trigger reserved bits not zero");
  chk_boot_stable: assert property ( // RL19
    boot_done && $past(boot_done) |-> $stable({sysmem_boot_flag, user_one_boot_flag,
      user_two_boot_flag, debug_loader_boot_flag}))
    else $error("boot flags changed after capture");

  cov_flash_delay: cover property (flash_state == FLASH_COUNT ##[1:1000] flash_power_on);
  cov_ram_at_zero_select_on: cover property (ram_at_zero_select && ram_select);
  cov_ext_irq: cover property (irq_request[0] && irq);
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import sysconfig_pkg::*;
  localparam logic [31:0] ID_VAL = 32'h0000_c3a1; // Arbitrary value
  // RC clock made from pclk, period in pclk cycles
  localparam int          RC_DIV = 4;
  localparam logic [5:0]  EF     = 6'b101010;
  localparam logic [5:0]  ER     = 6'b110100;
  localparam logic [5:0]  LF     = 6'b000010;
  localparam logic [5:0]  LR     = 6'b000100;

  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, mem_addr, rd;
  logic        pready, pslverr, er;
  boot_strap_t boot_strap;
  logic        ram_select, flash_select, ram_at_zero_select;
  logic        dma_serial1_route, dma_serial0_route;
  logic        low_power_wait_mode, rc_slow_sel, flash_power_on;
  logic        rc_clk = 1'b0;
  logic [1:0]  rc_cnt = 2'h0;
  logic        wake_pin_zero, wut_end_of_count, wake_line0;
  logic [15:0] ext_irq, irq_request;
  logic [1:0]  lp_regulator_current_sel;
  logic [2:0]  lp_reg_current_ma;
  logic        irq;
  int          miscompares, checks_done, rises;

  system_config_registers #(.DEVICE_ID(ID_VAL)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .boot_strap(boot_strap),
    .mem_addr(mem_addr), .ram_select(ram_select), .flash_select(flash_select),
    .ram_at_zero_select(ram_at_zero_select), .dma_serial1_route(dma_serial1_route),
    .dma_serial0_route(dma_serial0_route), .low_power_wait_mode(low_power_wait_mode),
    .rc_clk(rc_clk), .rc_slow_sel(rc_slow_sel), .flash_power_on(flash_power_on),
    .wake_pin_zero(wake_pin_zero), .wut_end_of_count(wut_end_of_count),
    .wake_line0(wake_line0), .ext_irq(ext_irq), .irq_request(irq_request),
    .lp_regulator_current_sel(lp_regulator_current_sel),
    .lp_reg_current_ma(lp_reg_current_ma), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    rc_cnt <= rc_cnt + 2'h1;
    rc_clk <= rc_cnt[1];
  end

  task summarize();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Registered answer: values read just after an edge are the pre-edge ones
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(er, 1'b0);
  endtask

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task watch(input int idx, input int n);
    logic prev;
    prev  = irq_request[idx];
    rises = 0;
    repeat (n) begin
      @(posedge pclk);
      if (irq_request[idx] === 1'b1 && prev !== 1'b1) rises++;
      prev = irq_request[idx];
    end
  endtask

  task pulse(input int n);
    @(posedge pclk);
    ext_irq[0] <= 1'b1;
    cyc(n);
    ext_irq[0] <= 1'b0;
    watch(0, 10);
  endtask

  task t_reset();
    rdc(OFS_BOOT_RAM_AT_ZERO_SELECT, 32'h0000_0480);
    rdc(OFS_TRIG_A, 32'h0000_ffff);
    rdc(OFS_TRIG_B, 32'h0);
    rdc(OFS_TRIG_C, 32'h0);
    rdc(OFS_POWER_WAKE, 32'h0000_0040);
    rdc(OFS_DEVICE_ID, ID_VAL);
    rdc(OFS_EVENT_MASK, 32'h0);
    chk(flash_power_on, 1'b1);
    $display("test reset done");
  endtask

  task t_reg0();
    boot_strap <= '0;
    wr(OFS_BOOT_RAM_AT_ZERO_SELECT, 32'hffff_fff1);
    rdc(OFS_BOOT_RAM_AT_ZERO_SELECT, 32'h0000_04b1);
    chk(dma_serial1_route, 1'b1);
    chk(dma_serial0_route, 1'b1);
    chk(ram_at_zero_select, 1'b1);
    mem_addr <= 32'h0000_0100;
    cyc(3);
    chk({ram_select, flash_select}, 2'b10);
    wr(OFS_BOOT_RAM_AT_ZERO_SELECT, 32'h0);
    cyc(2);
    chk({ram_select, flash_select}, 2'b01);
    chk({dma_serial1_route, dma_serial0_route}, 2'b00);
    mem_addr <= 32'ha000_0100;
    cyc(3);
    chk({ram_select, flash_select}, 2'b10);
    $display("test boot and routing done");
  endtask

  task t_regs();
    logic [7:0] ofs [3];
    logic [2:0] ma [4];
    ofs = '{OFS_TRIG_A, OFS_TRIG_B, OFS_TRIG_C};
    ma  = '{3'd6, 3'd4, 3'd4, 3'd2};
    wr(OFS_POWER_WAKE, 32'hffff_ffff);
    rdc(OFS_POWER_WAKE, 32'h0000_00ff);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_POWER_WAKE, c);
      cyc(2);
      chk(lp_regulator_current_sel, c[1:0]);
      chk(lp_reg_current_ma, ma[c]);
    end
    for (int i = 0; i < 3; i++) begin
      wr(ofs[i], 32'hffff_ffff);
      rdc(ofs[i], 32'h0000_ffff);
      wr(ofs[i], 32'h0);
    end
    wr(OFS_DEVICE_ID, 32'h0);
    rdc(OFS_DEVICE_ID, ID_VAL);
    wr(8'h10, 32'hffff_ffff);
    chk(er, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("test register access done");
  endtask

  task t_wake();
    wr(OFS_POWER_WAKE, 32'h0);
    wake_pin_zero    <= 1'b1;
    wut_end_of_count <= 1'b0;
    cyc(5);
    chk(wake_line0, 1'b1);
    wr(OFS_POWER_WAKE, 32'h8);
    cyc(3);
    chk(wake_line0, 1'b0);
    wut_end_of_count <= 1'b1;
    cyc(3);
    chk(wake_line0, 1'b1);
    $display("test wake source done");
  endtask

  task t_kinds();
    for (int k = 0; k < 6; k++) begin
      ext_irq[1] <= 1'b1;
      wr(OFS_TRIG_A, {30'h0, k[0], 1'b0});
      wr(OFS_TRIG_B, {30'h0, k[1], 1'b0});
      wr(OFS_TRIG_C, {30'h0, k[2], 1'b0});
      cyc(12);
      ext_irq[1] <= 1'b0;
      watch(1, 12);
      chk(rises, EF[k]);
      chk(irq_request[1], LF[k]);
      ext_irq[1] <= 1'b1;
      watch(1, 12);
      chk(rises, ER[k]);
      chk(irq_request[1], LR[k]);
    end
    $display("test trigger kinds done");
  endtask

  task t_filter();
    ext_irq <= 16'h0;
    wr(OFS_TRIG_A, 32'h0);
    wr(OFS_TRIG_B, 32'h0);
    wr(OFS_TRIG_C, 32'h1);
    wr(OFS_POWER_WAKE, 32'h4);
    cyc(8);
    pulse(1);
    chk(rises, 0);
    pulse(3);
    chk(rises, 1);
    wr(OFS_POWER_WAKE, 32'h0);
    pulse(1);
    chk(rises, 1);
    $display("test glitch filter done");
  endtask

  task t_irq();
    wr(OFS_EVENT_MASK, 32'h0);
    wr(OFS_EVENT_STATUS, 32'h7);
    pulse(3);
    rdc(OFS_EVENT_STATUS, 32'h4);
    chk(irq, 1'b0);
    wr(OFS_EVENT_MASK, 32'h4);
    cyc(3);
    chk(irq, 1'b1);
    wr(OFS_EVENT_STATUS, 32'h4);
    cyc(3);
    chk(irq, 1'b0);
    rdc(OFS_EVENT_STATUS, 32'h0);
    wr(OFS_EVENT_MASK, 32'h0);
    $display("test event interrupt done");
  endtask

  task flash(input logic slow, input logic [3:0] f, input int mult);
    int n;
    int exp;
    rc_slow_sel <= slow;
    wr(OFS_POWER_WAKE, {24'h0, f, 4'h0});
    wr(OFS_EVENT_STATUS, 32'h7);
    low_power_wait_mode <= 1'b1;
    cyc(10);
    chk(flash_power_on, 1'b0);
    low_power_wait_mode <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (flash_power_on !== 1'b1 && n < 2000);
    exp = f * mult * RC_DIV;
    chk(n >= exp && n <= exp + RC_DIV + 8, 1'b1);
    rdc(OFS_EVENT_STATUS, 32'h3);
    $display("test flash delay done");
  endtask

  task t_boot2();
    boot_strap <= '{sysmem: 1'b0, user_one: 1'b1, user_two: 1'b0, loader_in_ram: 1'b1};
    presetn    <= 1'b0;
    cyc(3);
    presetn    <= 1'b1;
    cyc(10);
    rdc(OFS_BOOT_RAM_AT_ZERO_SELECT, 32'h0000_0200);
    rdc(OFS_POWER_WAKE, 32'h0000_0040);
    $display("test second reset done");
  endtask

  initial begin
    miscompares = 0;
    checks_done = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    mem_addr = 32'h0;
    boot_strap = '{sysmem: 1'b1, user_one: 1'b0, user_two: 1'b0, loader_in_ram: 1'b1};
    low_power_wait_mode = 1'b0;
    rc_slow_sel = 1'b0;
    wake_pin_zero = 1'b0;
    wut_end_of_count = 1'b0;
    // Idle high so the reset low-level trigger code raises requests only in the first three cycles after reset
    ext_irq = 16'hffff;
    cyc(20);
    presetn <= 1'b1;
    cyc(10);
    t_reset();
    t_reg0();
    t_regs();
    t_wake();
    t_kinds();
    t_filter();
    t_irq();
    flash(1'b0, 4'h1, FAST_RC_MULT);
    flash(1'b1, 4'h3, 1);
    t_boot2();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    summarize();
  end
endmodule
